// >>> hdl/usm_cfg.svh
// Constants of the master-SPI serial port: register indices, bit positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef USM_CFG_SVH
`define USM_CFG_SVH
// Register indices; the byte address on the bus is four times the index.
`define USM_IDX_STATUS    8'hC0
`define USM_IDX_CTRL      8'hC1
`define USM_IDX_MODE      8'hC2
`define USM_IDX_DIV       8'hC4
`define USM_IDX_DATA      8'hC6
// Status register bits.
`define USM_RX_DONE_BIT   7
`define USM_TX_DONE_BIT   6
`define USM_TX_EMPTY_BIT  5
// Interrupt enable and control register bits.
`define USM_RX_IE_BIT     7
`define USM_TX_IE_BIT     6
`define USM_EMPTY_IE_BIT  5
`define USM_RXEN_BIT      4
`define USM_TXEN_BIT      3
// Mode and frame control register bits.
`define USM_MODE_HI_BIT   7
`define USM_MODE_LO_BIT   6
`define USM_ORDER_BIT     2
`define USM_PHASE_BIT     1
`define USM_POL_BIT       0
`define USM_MODE_MSPI     2'h3
// Reset values.
`define USM_STATUS_RST    8'h20
`define USM_CTRL_RST      8'h00
`define USM_MODE_RST      8'h06
`define USM_DIV_RST       12'h000
// Clock edges per frame: two for each of eight bits.
`define USM_EDGES_LAST    4'hF
`endif

// >>> hdl/usm_pkg.sv
// Types of the master-SPI serial port.
// Assumes no other package.
package usm_pkg;
  typedef enum logic [1:0] {
    USM_IDLE = 2'b00,
    USM_RUN  = 2'b01
  } usm_state_t;
endpackage

// >>> hdl/usm_rx_buf.sv
// Receive buffer: a shift-style FIFO whose head word sits in a register.
// Assumes one clock; a push into a full buffer is dropped unless a pop comes in the same cycle.
`timescale 1ns/1ps
module usm_rx_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_q,
  output logic                  not_empty,
  output logic                  full
);
  if (DEPTH < 1 || DEPTH > 15) begin : g_chk
    $error("usm_rx_buf: DEPTH out of range");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [3:0]       cnt_q;
  logic             do_pop;
  logic             do_push;

  assign not_empty = (cnt_q != 4'h0);
  assign full      = (cnt_q == 4'(DEPTH));
  assign do_pop    = pop && not_empty;
  // The newest byte is lost on overflow; older bytes stay.
  assign do_push   = push && (!full || do_pop);
  assign head_q    = mem_q[0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (flush) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'(do_push) - 4'(do_pop);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (do_pop) begin
          mem_q[i] <= (i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
        end
        if (do_push && (4'(i) == (cnt_q - 4'(do_pop)))) begin
          mem_q[i] <= push_data;
        end
      end
    end
  end
endmodule

// >>> hdl/usm_top.sv
// Serial port in master SPI mode with an AHB-Lite register slave.
// Assumes the pin wrapper resolves pins from the enables and the CPU gives its global interrupt enable.
`timescale 1ns/1ps
`include "usm_cfg.svh"
// Functional notes
// RULE1: rx done flag is high exactly while the receive buffer holds unread data.
// RULE2: disabling the receiver flushes the buffer, so rx done drops.
// RULE3: tx done sets when the frame has shifted out and buffer is empty.
// RULE4: tx done clears on interrupt service or a one written to it.
// RULE5: tx buffer empty flag shows room for a byte; it is one after reset.
// RULE6: framing, overrun and parity flags are unused and read zero.
// RULE7: software writes zeros to status bits 4 to 0.
// RULE8: rx interrupt needs its enable, the global enable and rx done.
// RULE9: tx done interrupt needs its enable, the global enable and tx done.
// RULE10: empty interrupt needs its enable, the global enable and the empty flag.
// RULE11: receiver enable hands the serial input pin to the receiver.
// RULE12: transmitter enable takes the output pin; disable waits for idle.
// RULE13: mode field 11 selects master SPI; other codes leave it inactive.
// RULE14: order, phase and polarity are taken in the write enabling SPI.
// RULE15: bit order one sends LSB first, zero sends MSB first.
// RULE16: phase bit picks sampling on the leading or trailing clock edge.
// RULE17: polarity bit sets the idle level of the transfer clock.
// RULE18: software writes zeros to reserved control and mode bits.
// RULE19: transmit holding buffer plus shifter; receive has one extra level.
// RULE20: no write collision flag and no double speed bit.
// RULE21: master only: output pin, input pin and transfer clock pin.
// RULE22: no slave select; software drives it on a general pin.
// RULE23: transfer clock is the clock over two times divisor plus one.
// RULE24: data set up and sampled on opposite edges of the transfer clock.
// RULE25: writing the data register starts each eight-bit transfer.
// RULE26: on receive overflow the newest byte is dropped.
// RULE27: rx done sets in the cycle after the eighth bit is sampled.
module usm_top #(
  parameter int RX_DEPTH = 2,
  parameter int DIV_W    = 12
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [9:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        cpu_status_word_gie,
  input  wire logic        tx_done_irq_ack,
  output logic             rx_done_irq,
  output logic             tx_done_irq,
  output logic             tx_empty_irq,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             transfer_clock_pin_o,
  output logic             transfer_clock_pin_oe
);
  if (RX_DEPTH < 1 || DIV_W != 12) begin : g_chk
    $error("usm_top: unsupported parameter");
  end

  function automatic logic first_bit(input logic [7:0] sr, input logic lsb);
    first_bit = lsb ? sr[0] : sr[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] sr, input logic lsb);
    shift_out = lsb ? {1'b0, sr[7:1]} : {sr[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b, input logic lsb);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  usm_pkg::usm_state_t state_q;
  logic [7:0]       ctrl_q;
  logic [7:0]       mode_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] cnt_q;
  logic [3:0]       edge_q;
  logic             sck_q;
  logic             mosi_q;
  logic [7:0]       tx_sr_q;
  logic [7:0]       rx_sr_q;
  logic [7:0]       txb_q;
  logic             txb_full_q;
  logic             tx_done_q;
  logic             tx_active_q;
  logic             rx_s1_q;
  logic             rx_s2_q;
  logic             wr_pend_q;
  logic [7:0]       wr_idx_q;
  logic [31:0]      hrdata_q;
  logic             addr_ok;
  logic             rd_data;
  logic             wr_data;
  logic             wr_status;
  logic             wr_ctrl;
  logic             wr_mode;
  logic             wr_div;
  logic             mspi_on;
  logic             rxen;
  logic             lsb_first;
  logic             cpha;
  logic             cpol;
  logic             tick;
  logic             sample_edge;
  logic             setup_edge;
  logic             frame_end;
  logic             start;
  logic             rx_push;
  logic [7:0]       rx_byte;
  logic [7:0]       rx_head;
  logic             rx_avail;
  logic [7:0]       status_rd;

  // Bus slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addr_ok   = hsel && hready && htrans[1] && (haddr[1:0] == 2'h0);
  assign rd_data   = addr_ok && !hwrite && (haddr[9:2] == `USM_IDX_DATA);
  assign wr_data   = wr_pend_q && (wr_idx_q == `USM_IDX_DATA);
  assign wr_status = wr_pend_q && (wr_idx_q == `USM_IDX_STATUS);
  assign wr_ctrl   = wr_pend_q && (wr_idx_q == `USM_IDX_CTRL);
  assign wr_mode   = wr_pend_q && (wr_idx_q == `USM_IDX_MODE);
  assign wr_div    = wr_pend_q && (wr_idx_q == `USM_IDX_DIV);

  assign mspi_on   = ({mode_q[`USM_MODE_HI_BIT], mode_q[`USM_MODE_LO_BIT]} == `USM_MODE_MSPI); // see RULE13
  assign rxen      = ctrl_q[`USM_RXEN_BIT]; // see RULE11
  assign lsb_first = mode_q[`USM_ORDER_BIT];
  assign cpha      = mode_q[`USM_PHASE_BIT];
  assign cpol      = mode_q[`USM_POL_BIT];

  // Error flags are not kept, so status bits 4 to 0 read zero.
  assign status_rd = {rx_avail, tx_done_q, !txb_full_q, 5'h00}; // see RULE1, see RULE5, see RULE6

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= haddr[9:2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (haddr[9:2] == `USM_IDX_STATUS) begin
        hrdata_q <= {24'h000000, status_rd};
      end else if (haddr[9:2] == `USM_IDX_CTRL) begin
        hrdata_q <= {24'h000000, ctrl_q[7:3], 3'h0};
      end else if (haddr[9:2] == `USM_IDX_MODE) begin
        hrdata_q <= {24'h000000, mode_q[7:6], 3'h0, mode_q[2:0]};
      end else if (haddr[9:2] == `USM_IDX_DIV) begin
        hrdata_q <= {20'h00000, div_q};
      end else if (haddr[9:2] == `USM_IDX_DATA) begin
        hrdata_q <= {24'h000000, rx_head};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // No collision flag and no speed doubling: the divisor alone sets the rate.
  always_ff @(posedge clk or negedge rstn) begin // see RULE20
    if (!rstn) begin
      ctrl_q <= `USM_CTRL_RST;
      mode_q <= `USM_MODE_RST;
      div_q  <= `USM_DIV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {hwdata[7:3], 3'h0};
      end
      if (wr_mode) begin
        mode_q <= {hwdata[7:6], 3'h0, hwdata[2:0]}; // see RULE14
      end
      if (wr_div) begin
        div_q <= hwdata[DIV_W-1:0];
      end
    end
  end

  // A disable of the transmitter waits until shifter and buffer are empty.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_active_q <= 1'b0;
    end else if (ctrl_q[`USM_TXEN_BIT]) begin
      tx_active_q <= 1'b1;
    end else if (state_q == usm_pkg::USM_IDLE && !txb_full_q) begin
      tx_active_q <= 1'b0; // see RULE12
    end
  end

  // Transmit holding buffer; a write while it is full is dropped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txb_q      <= 8'h00;
      txb_full_q <= 1'b0;
    end else if (wr_data && !txb_full_q) begin
      txb_q      <= hwdata[7:0];
      txb_full_q <= 1'b1; // see RULE19
    end else if (start) begin
      txb_full_q <= 1'b0; // see RULE5
    end
  end

  // Set wins over both clears.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_done_q <= 1'b0;
    end else if (frame_end && !txb_full_q) begin
      tx_done_q <= 1'b1; // see RULE3
    end else if (tx_done_irq_ack || (wr_status && hwdata[`USM_TX_DONE_BIT])) begin
      tx_done_q <= 1'b0; // see RULE4
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
    end else begin
      rx_s1_q <= serial_in_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Transfer engine: a half period lasts divisor plus one clocks.
  assign tick        = (state_q == usm_pkg::USM_RUN) && (cnt_q == '0); // see RULE23
  assign sample_edge = tick && (edge_q[0] == cpha); // see RULE16, see RULE24
  assign setup_edge  = tick && (edge_q[0] != cpha);
  assign frame_end   = tick && (edge_q == `USM_EDGES_LAST);
  assign start       = (state_q == usm_pkg::USM_IDLE) && txb_full_q && tx_active_q && mspi_on; // see RULE25
  assign rx_byte     = shift_in(rx_sr_q, rx_s2_q, lsb_first);
  assign rx_push     = sample_edge && (edge_q[3:1] == 3'h7) && rxen; // see RULE27

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= usm_pkg::USM_IDLE;
      cnt_q   <= '0;
      edge_q  <= 4'h0;
    end else begin
      case (state_q)
        usm_pkg::USM_IDLE: begin
          if (start) begin
            state_q <= usm_pkg::USM_RUN;
            cnt_q   <= div_q;
            edge_q  <= 4'h0;
          end
        end
        usm_pkg::USM_RUN: begin
          if (!mspi_on) begin
            state_q <= usm_pkg::USM_IDLE;
          end else if (tick) begin
            cnt_q  <= div_q;
            edge_q <= edge_q + 4'h1;
            if (frame_end) begin
              state_q <= usm_pkg::USM_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - DIV_W'(1);
          end
        end
        default: begin
          state_q <= usm_pkg::USM_IDLE;
        end
      endcase
    end
  end

  // Clock toggles on every edge and rests at the polarity level.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
    end else if (state_q == usm_pkg::USM_IDLE || !mspi_on) begin
      sck_q <= cpol; // see RULE17
    end else if (tick) begin
      sck_q <= !sck_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_sr_q <= 8'h00;
      mosi_q  <= 1'b1;
    end else if (start) begin
      if (!cpha) begin
        mosi_q  <= first_bit(txb_q, lsb_first); // see RULE15
        tx_sr_q <= shift_out(txb_q, lsb_first);
      end else begin
        tx_sr_q <= txb_q;
      end
    end else if (setup_edge) begin
      mosi_q  <= first_bit(tx_sr_q, lsb_first);
      tx_sr_q <= shift_out(tx_sr_q, lsb_first);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sr_q <= 8'h00;
    end else if (sample_edge) begin
      rx_sr_q <= rx_byte;
    end
  end

  usm_rx_buf #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (!rxen),
    .push      (rx_push),
    .push_data (rx_byte),
    .pop       (rd_data),
    .head_q    (rx_head),
    .not_empty (rx_avail),
    .full      ()
  ); // see RULE2, see RULE19, see RULE26

  assign rx_done_irq  = ctrl_q[`USM_RX_IE_BIT] && cpu_status_word_gie && rx_avail; // see RULE8
  assign tx_done_irq  = ctrl_q[`USM_TX_IE_BIT] && cpu_status_word_gie && tx_done_q; // see RULE9
  assign tx_empty_irq = ctrl_q[`USM_EMPTY_IE_BIT] && cpu_status_word_gie && !txb_full_q; // see RULE10

  // Master only; no slave select output exists.
  assign serial_out_pin_o      = mosi_q; // see RULE21
  assign serial_out_pin_oe     = tx_active_q; // see RULE12
  assign transfer_clock_pin_o  = sck_q;
  assign transfer_clock_pin_oe = tx_active_q;

  // Helper: clocks spent in the running frame.
  logic [16:0] fr_cyc_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fr_cyc_q <= 17'h00000;
    end else if (start) begin
      fr_cyc_q <= 17'h00001;
    end else if (state_q == usm_pkg::USM_RUN) begin
      fr_cyc_q <= fr_cyc_q + 17'h00001;
    end
  end

  rx_set_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE27
    rx_push && !rd_data |=> rx_avail) else $error("rx flag not set after eighth bit");
  rx_flush_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE2
    !rxen ##1 !rxen |-> !rx_avail && !rx_done_irq) else $error("rx buffer not flushed");
  tx_done_set_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE3
    frame_end && !txb_full_q |=> tx_done_q) else $error("tx done not set at frame end");
  tx_done_clr_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE4
    tx_done_irq_ack && !frame_end |=> !tx_done_q) else $error("tx done not cleared by service");
  tx_empty_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE5
    wr_data && !txb_full_q && !start |=> !status_rd[`USM_TX_EMPTY_BIT]) else $error("empty flag stuck");
  frame_len_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE23
    frame_end && $stable(div_q) |-> fr_cyc_q == 17'(16 * (32'(div_q) + 1))) else $error("frame length wrong");
  sck_idle_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE17
    state_q == usm_pkg::USM_IDLE |=> sck_q == $past(cpol)) else $error("clock not idle");
  txen_hold_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE12
    txb_full_q && tx_active_q |=> serial_out_pin_oe) else $error("pin released with data pending");
  err_zero_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE6
    addr_ok && !hwrite && haddr[9:2] == `USM_IDX_STATUS |=> hrdata[4:0] == 5'h00) else $error("error bits set");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rstn) // see RULE8
    $rose(rx_done_irq) |-> $past(rx_push) || $rose(cpu_status_word_gie) || $rose(ctrl_q[7])) else $error("bad rx irq");

  frame_cov: cover property (@(posedge clk) disable iff (!rstn) frame_end && rx_push);
  b2b_cov: cover property (@(posedge clk) disable iff (!rstn) frame_end && txb_full_q);
  ovf_cov: cover property (@(posedge clk) disable iff (!rstn) rx_push && !rd_data && rx_avail ##1 rx_avail);
  cpha_cov: cover property (@(posedge clk) disable iff (!rstn) frame_end && cpha && lsb_first);
endmodule

// >>> tb/usm_spi_slave.sv
// Behavioural SPI slave that faces the port's serial pins.
// Assumes mode inputs match the port and load is pulsed once the clock pin has settled.
`timescale 1ns/1ps
module usm_spi_slave (
  input  wire logic       clk,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic       load,
  input  wire logic [7:0] ld_val,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  output logic            done,
  output logic      [7:0] got
);
  logic [7:0] dat   = 8'h00;
  logic [7:0] sh    = 8'h00;
  logic       sck_q = 1'b0;
  int         n     = 0;
  int         k     = 0;
  logic       lead;
  logic       trail;
  // No slave select exists, so the frame is tracked by counting sample edges.
  assign lead  = (sck_q == cpol) && (sck != cpol);
  assign trail = (sck_q != cpol) && (sck == cpol);
  assign miso  = lsb ? dat[k] : dat[7-k];
  initial begin
    done = 1'b0;
    got  = 8'h00;
  end
  always @(posedge clk) begin
    sck_q <= sck;
    done  <= 1'b0;
    if (load) begin
      dat <= ld_val;
      n   <= 0;
      k   <= 0;
    end else if (cpha ? trail : lead) begin
      sh <= lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      n  <= n + 1;
      if (n == 7) begin
        // The next frame answers with the inverse byte, so back-to-back frames never carry the same byte.
        done <= 1'b1;
        got  <= lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
        dat  <= ~dat;
        n    <= 0;
      end
    end else if (cpha ? lead : trail) begin
      k <= n;
    end
  end
endmodule

// >>> tb/usm_top_tb_top.sv
// Self-checking bench: bus driver, SPI slave model and result queues for the serial port.
// Assumes the port is the only bus slave and the slave model shares its clock.
`timescale 1ns/1ps
`include "usm_cfg.svh"
module usm_top_tb_top;
  localparam logic [9:0] A_ST = {`USM_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_CT = {`USM_IDX_CTRL, 2'b00};
  localparam logic [9:0] A_MD = {`USM_IDX_MODE, 2'b00};
  localparam logic [9:0] A_DT = {`USM_IDX_DATA, 2'b00};
  localparam int         DIV  = 3;
  logic        clk, rstn, hsel, hwrite, hready, gie, ack, ld, pol, pha, lsb, dp_rd;
  logic [9:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, seed;
  logic        hreadyout, hresp, rx_irq, tx_irq, em_irq, miso, mosi, mosi_oe, sck, sck_oe, sp_done;
  logic [7:0]  ld_val, sp_got, sl;
  logic [31:0] exp_rd[$];
  logic [7:0]  exp_sp[$];
  logic [7:0]  rxq[$];
  int          errors, checks, cyc;
  usm_top u_usm_top (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .cpu_status_word_gie(gie), .tx_done_irq_ack(ack), .rx_done_irq(rx_irq), .tx_done_irq(tx_irq),
    .tx_empty_irq(em_irq), .serial_in_pin(miso), .serial_out_pin_o(mosi), .serial_out_pin_oe(mosi_oe),
    .transfer_clock_pin_o(sck), .transfer_clock_pin_oe(sck_oe));
  usm_spi_slave u_usm_spi_slave (.clk(clk), .cpol(pol), .cpha(pha), .lsb(lsb), .load(ld), .ld_val(ld_val),
    .sck(sck), .mosi(mosi), .miso(miso), .done(sp_done), .got(sp_got));
  assign hready = hreadyout;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t register value %h, expected %h", $time, got, exp);
    end
  endtask
  task cmp_spi(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t slave received %h, expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; for a read, d is the value expected in the data phase.
  task xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h0;
    if (!wr) begin
      exp_rd.push_back(d);
      dp_rd <= 1'b1;
    end
    do @(posedge clk); while (hready !== 1'b1);
    dp_rd <= 1'b0;
  endtask
  task frame(input logic [31:0] r);
    exp_sp.push_back(r[7:0]);
    rxq.push_back(sl);
    sl = ~sl;
    xfer(1'b1, A_DT, {24'h0, r[7:0]});
  endtask
  task cfg(input logic [2:0] m);
    {lsb, pha, pol} <= m;
    xfer(1'b1, A_MD, {24'h0, 2'b11, 3'b000, m});
    repeat (2) @(posedge clk);
    ld     <= 1'b1;
    ld_val <= 8'($random(seed));
    @(posedge clk);
    ld     <= 1'b0;
    sl     = ld_val;
    @(negedge clk);
    cmp_reg({31'h0, sck}, {31'h0, pol});
    @(posedge clk);
  endtask
  task wait_done;
    for (int i = 0; i < 400 && tx_irq !== 1'b1; i++) @(negedge clk);
    if (tx_irq !== 1'b1) begin
      errors++;
      $display("[ERR] %0t transmit complete never came", $time);
    end
    @(posedge clk);
  endtask
  // Outputs are read at the falling edge, after any input change of the last rising edge has settled.
  task chk(input logic pins, input logic [31:0] exp);
    @(negedge clk);
    cmp_reg(pins ? {28'h0, hreadyout, hresp, mosi_oe, sck_oe} : {29'h0, rx_irq, tx_irq, em_irq}, exp);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (dp_rd) cmp_reg(hrdata, exp_rd.pop_front());
    if (sp_done) cmp_spi(sp_got, exp_sp.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t run exceeded its cycle limit", $time);
      end_of_test;
    end
  end
  initial begin
    {rstn, hsel, hwrite, gie, ack, ld, pol, pha, lsb, dp_rd} = '0;
    {haddr, htrans, hwdata, ld_val, sl, errors, checks, cyc} = '0;
    hsize = 3'b010;
    seed  = 32'h735b;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, A_ST, 32'h20);
    xfer(1'b0, A_CT, 32'h00);
    xfer(1'b0, A_MD, 32'h06);
    xfer(1'b0, 10'h3FC, 32'h0);
    $display("test reset values done");
    xfer(1'b1, A_CT, 32'hF8);
    xfer(1'b1, {`USM_IDX_DIV, 2'b00}, DIV);
    chk(1'b0, 32'h0);
    gie <= 1'b1;
    chk(1'b0, 32'h1);
    for (int i = 0; i < 8; i++) begin
      cfg(i[2:0]);
      frame($random(seed));
      wait_done;
      chk(1'b0, 32'h7);
      xfer(1'b0, A_ST, 32'hE0);
      xfer(1'b0, A_DT, rxq.pop_front());
      xfer(1'b0, A_ST, 32'h60);
      if (i[0]) begin
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
      end else xfer(1'b1, A_ST, 32'h40);
      chk(1'b0, 32'h1);
    end
    $display("test modes and orders done");
    cfg(3'b000);
    frame($random(seed));
    frame($random(seed));
    xfer(1'b0, A_ST, 32'h00);
    wait_done;
    xfer(1'b1, A_ST, 32'h40);
    frame($random(seed));
    wait_done;
    void'(rxq.pop_back());
    xfer(1'b0, A_DT, rxq.pop_front());
    xfer(1'b0, A_DT, rxq.pop_front());
    xfer(1'b0, A_ST, 32'h60);
    $display("test overflow done");
    xfer(1'b1, A_ST, 32'h40);
    xfer(1'b1, A_MD, 32'h80);
    frame($random(seed));
    repeat (16 * (DIV + 1) + 8) @(posedge clk);
    xfer(1'b0, A_ST, 32'h00);
    xfer(1'b1, A_MD, 32'hC0);
    wait_done;
    xfer(1'b0, A_DT, rxq.pop_front());
    xfer(1'b1, A_ST, 32'h40);
    frame($random(seed));
    xfer(1'b1, A_CT, 32'hF0);
    chk(1'b1, 32'hB);
    wait_done;
    repeat (2) @(posedge clk);
    chk(1'b1, 32'h8);
    xfer(1'b1, A_CT, 32'hE0);
    xfer(1'b0, A_ST, 32'h60);
    void'(rxq.pop_front());
    $display("test refusal and disable done");
    end_of_test;
  end
endmodule
